// [core/sms_port.sv]
`timescale 1ns/1ps
module sms_port (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_n,
    // Register port.
    input wire sms_pkg::sms_regreq_t regReq,
    output logic [7:0] regRdData,
    // Serial pins.
    input wire sms_pkg::sms_pin_in_t pinIn,
    output sms_pkg::sms_pin_out_t pinOut,
    // Slave access port towards internal registers.
    output sms_pkg::sms_req_t dmaReq,
    output logic dmaValid,
    input wire logic dmaReady,
    input wire logic dmaRdValid,
    input wire logic [7:0] dmaRdData
);
    import sms_pkg::*;

    // ------------------------------------------------------------
    // Reset release and state.
    // ------------------------------------------------------------
    logic [1:0] rstPipe_q;
    logic rstSyncN;
    sms_state_t q;
    sms_state_t d;
    logic isMaster, fnOn, cpol, cpha, share, mDin, sDin, tick, sample, rise, fall;
    logic startWr, startRd;
    logic [7:0] sByte;
    logic [1:0] cnt;
    sms_req_t req;

    function automatic logic [15:0] nextAddr(input logic [15:0] a, input logic inc);
        nextAddr = inc ? a + 16'h0001 : a;
    endfunction

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstPipe_q <= 2'h0;
        end else begin
            rstPipe_q <= {rstPipe_q[0], 1'b1};
        end
    end
    assign rstSyncN = rstPipe_q[1];

    // ------------------------------------------------------------
    // Next-state logic.
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        sByte = 8'h00;
        cnt = q.bufCnt;
        req = '0;
        isMaster = q.ctrl[CTRL_MASTER];
        fnOn = q.clkPin[CLK_FN];
        cpol = q.mode[MODE_CPOL];
        cpha = q.mode[MODE_CPHA];
        share = q.ctrl[CTRL_SHARE];
        mDin = share ? q.sdioF : q.sdiF;
        sDin = mDin;
        sample = 1'b0;
        // Pin filters: a level counts once the second and third stages agree.
        d.sckS = {q.sckS[1:0], pinIn.sck};
        d.selNS = {q.selNS[1:0], pinIn.selN};
        d.sdiS = {q.sdiS[1:0], pinIn.sdi};
        d.sdioS = {q.sdioS[1:0], pinIn.sdio};
        if (q.sckS[1] == q.sckS[2]) d.sckF = q.sckS[2];
        if (q.selNS[1] == q.selNS[2]) d.selNF = q.selNS[2];
        if (q.sdiS[1] == q.sdiS[2]) d.sdiF = q.sdiS[2];
        if (q.sdioS[1] == q.sdioS[2]) d.sdioF = q.sdioS[2];

        // Register port: read data is registered, writes take effect at once.
        if (regReq.rd) begin
            unique case (regReq.addr)
                ADDR_DATA: d.rdData = q.shift;
                ADDR_CTRL: d.rdData = {q.ctrl[7], q.mst == M_RUN, q.ctrl[5:0]};
                ADDR_CLKPIN: d.rdData = q.clkPin;
                ADDR_MODE: d.rdData = q.mode;
                default: d.rdData = 8'h00;
            endcase
        end
        startWr = isMaster && regReq.wr && regReq.addr == ADDR_DATA && q.mst == M_IDLE;
        startRd = isMaster && regReq.rd && regReq.addr == ADDR_DATA && q.mst == M_IDLE
            && q.ctrl[CTRL_RDEN];
        if (regReq.wr) begin
            unique case (regReq.addr)
                ADDR_CTRL: d.ctrl = regReq.wdata & ~(8'h01 << CTRL_BUSY);
                ADDR_CLKPIN: d.clkPin = regReq.wdata;
                ADDR_MODE: d.mode = regReq.wdata;
                default: ;
            endcase
        end

        // Master engine: sixteen clock edges per byte.
        tick = q.divCnt == q.clkPin[6:0];
        if (startWr || startRd) begin
            if (startWr) d.shift = regReq.wdata;
            d.mst = M_RUN;
            d.divCnt = 7'h00;
            d.edgeCnt = 4'h0;
        end else if (q.mst == M_RUN) begin
            if (tick) begin
                d.divCnt = 7'h00;
                d.pinOut.sckOut = ~q.pinOut.sckOut;
                sample = q.edgeCnt[0] == cpha;
                if (sample) begin
                    d.rxb = mDin;
                end else if (!(cpha && q.edgeCnt == 4'h0)) begin
                    d.shift = {q.shift[6:0], q.rxb};
                end
                if (q.edgeCnt == EDGE_LAST) begin
                    if (cpha) d.shift = {q.shift[6:0], mDin};
                    d.mst = M_IDLE;
                end
                d.edgeCnt = q.edgeCnt + 4'h1;
            end else begin
                d.divCnt = q.divCnt + 7'h01;
            end
        end else begin
            d.pinOut.sckOut = d.mode[MODE_CPOL];
        end

        // Two-entry buffer between slave link and access port.
        if (q.bufValid && dmaReady) begin
            cnt = q.bufCnt - 2'h1;
            d.bufMem[0] = q.bufMem[1];
        end
        if (q.pend && q.bufCnt != BUF_DEPTH) begin
            d.bufMem[cnt[0]] = q.pendReq;
            cnt = cnt + 2'h1;
            d.pend = 1'b0;
        end
        d.bufCnt = cnt;
        d.bufValid = cnt != 2'h0;
        if (dmaRdValid) d.rdBuf = dmaRdData;

        // Slave engine, framed by chip select; modes 0 and 3 both capture on rise.
        d.sckPrev = q.sckF;
        rise = q.sckF && !q.sckPrev;
        fall = !q.sckF && q.sckPrev;
        if (isMaster || q.selNF) begin
            d.sPh = PH_CMD;
            d.sBit = 3'h0;
            d.sLoad = 1'b0;
            d.sTx = q.rdBuf;
        end else if (rise) begin
            sByte = {q.sRx[6:0], sDin};
            d.sRx = sByte;
            d.sBit = q.sBit + 3'h1;
            if (q.sBit == BIT_LAST) begin
                unique case (q.sPh)
                    PH_CMD: begin
                        d.sCmdRd = sByte[7];
                        d.sPh = PH_ADRH;
                    end
                    PH_ADRH: begin
                        d.sAddr[15:8] = sByte;
                        d.sPh = PH_ADRL;
                    end
                    PH_ADRL: begin
                        d.sAddr[7:0] = sByte;
                        d.sPh = PH_DUMMY;
                        req = '{wr: 1'b0, addr: {q.sAddr[15:8], sByte}, data: 8'h00};
                        d.pend = q.sCmdRd && q.sActive;
                        d.sLoad = 1'b1;
                    end
                    PH_DUMMY, PH_DATA: begin
                        d.sPh = PH_DATA;
                        d.sLoad = 1'b1;
                        if (q.sPh == PH_DATA) begin
                            d.sAddr = nextAddr(q.sAddr, q.ctrl[CTRL_AINC]);
                            if (!q.sCmdRd && q.sAddr == SLV_KEY_ADDR) begin
                                d.clkPin = sByte;
                                if (sByte == SLV_KEY) d.sActive = 1'b1;
                            end else if (!q.sCmdRd) begin
                                req = '{wr: 1'b1, addr: q.sAddr, data: sByte};
                                d.pend = q.sActive;
                            end
                        end
                    end
                    default: d.sPh = PH_CMD;
                endcase
            end
        end else if (fall) begin
            if (q.sLoad) begin
                d.sTx = q.rdBuf;
                d.sLoad = 1'b0;
                if (q.sPh == PH_DATA && q.sCmdRd) begin
                    req = '{wr: 1'b0, addr: nextAddr(q.sAddr, q.ctrl[CTRL_AINC]), data: 8'h00};
                    d.pend = q.sActive;
                end
            end else begin
                d.sTx = {q.sTx[6:0], 1'b0};
            end
        end
        if (d.pend && !q.pend) d.pendReq = req;
        if (d.pend && q.pend && (req != '0)) d.pendReq = req;

        // Pin outputs, released unless the serial function owns the pins.
        d.pinOut.sckOe = d.clkPin[CLK_FN] && d.ctrl[CTRL_MASTER];
        d.pinOut.selNOut = d.ctrl[CTRL_CS];
        d.pinOut.selNOe = d.clkPin[CLK_FN] && d.ctrl[CTRL_MASTER];
        if (d.ctrl[CTRL_MASTER]) begin
            // The data line holds on sampling edges, so the far side never sees it move.
            if (!sample) d.pinOut.sdoOut = d.shift[7];
            d.pinOut.sdoOe = d.clkPin[CLK_FN] && !d.ctrl[CTRL_ODIS]
                && !(d.ctrl[CTRL_SHARE] && d.ctrl[CTRL_RDEN]);
        end else begin
            d.pinOut.sdoOut = d.sTx[7];
            d.pinOut.sdoOe = d.clkPin[CLK_FN] && d.sActive && !d.selNF && d.sCmdRd
                && (d.sPh == PH_DATA);
        end
    end

    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    assign regRdData = q.rdData;
    assign pinOut = q.pinOut;
    assign dmaReq = q.bufMem[0];
    assign dmaValid = q.bufValid;

    // ------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------
    // Helper counters measure clock edges and half periods of a byte.
    logic [4:0] toggCnt;
    logic [6:0] halfCnt;
    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            toggCnt <= 5'h00;
            halfCnt <= 7'h00;
        end else begin
            if (q.mst == M_IDLE) toggCnt <= 5'h00;
            else if (q.pinOut.sckOut != d.pinOut.sckOut) toggCnt <= toggCnt + 5'h01;
            if (q.mst == M_IDLE || q.pinOut.sckOut != d.pinOut.sckOut) halfCnt <= 7'h00;
            else halfCnt <= halfCnt + 7'h01;
        end
    end

    a_slave_after_reset: assert property (@(posedge core_clk)
        $rose(rstSyncN) |-> !q.ctrl[CTRL_MASTER]) else $error("not slave after reset");
    a_pins_released: assert property (@(posedge core_clk) disable iff (!rstSyncN)
        !q.clkPin[CLK_FN] |-> !(pinOut.sckOe || pinOut.selNOe || pinOut.sdoOe))
        else $error("pins driven without serial function");
    a_half_period: assert property (@(posedge core_clk) disable iff (!rstSyncN)
        (q.mst == M_RUN && q.pinOut.sckOut != d.pinOut.sckOut && $stable(q.clkPin))
        |-> halfCnt == q.clkPin[6:0]) else $error("half period length wrong");
    a_eight_clocks: assert property (@(posedge core_clk) disable iff (!rstSyncN)
        $fell(q.mst == M_RUN) |-> $past(toggCnt) == EDGES_PER_BYTE - 5'h01)
        else $error("byte did not take sixteen edges");
    a_idle_level: assert property (@(posedge core_clk) disable iff (!rstSyncN)
        (q.mst == M_IDLE && $past(q.mst == M_IDLE) && $stable(q.mode))
        |-> pinOut.sckOut == q.mode[MODE_CPOL]) else $error("idle clock level wrong");
    a_select_follows: assert property (@(posedge core_clk) disable iff (!rstSyncN)
        (q.ctrl[CTRL_MASTER] && q.clkPin[CLK_FN]) |-> pinOut.selNOe
        && pinOut.selNOut == q.ctrl[CTRL_CS]) else $error("select does not follow control");
    a_output_disable: assert property (@(posedge core_clk) disable iff (!rstSyncN)
        (q.ctrl[CTRL_MASTER] && q.ctrl[CTRL_ODIS]) |-> !pinOut.sdoOe)
        else $error("data driven while disabled");
    a_busy_read: assert property (@(posedge core_clk) disable iff (!rstSyncN)
        (regReq.rd && regReq.addr == ADDR_CTRL) |=> regRdData[CTRL_BUSY] == $past(q.mst == M_RUN))
        else $error("busy flag wrong");
    a_start_busy: assert property (@(posedge core_clk) disable iff (!rstSyncN)
        (startWr || startRd) |=> q.mst == M_RUN ##1 q.mst == M_RUN)
        else $error("busy did not set on start");
    a_slave_gate: assert property (@(posedge core_clk) disable iff (!rstSyncN)
        !q.sActive |-> !dmaValid && !q.pend) else $error("slave access before activation");
    a_read_gate: assert property (@(posedge core_clk) disable iff (!rstSyncN)
        (regReq.rd && regReq.addr == ADDR_DATA && q.mst == M_IDLE && !q.ctrl[CTRL_RDEN])
        |=> q.mst == M_IDLE) else $error("data read started clocks without read enable");
    a_share_quiet: assert property (@(posedge core_clk) disable iff (!rstSyncN)
        (q.ctrl[CTRL_MASTER] && q.ctrl[CTRL_SHARE] && q.ctrl[CTRL_RDEN]) |-> !pinOut.sdoOe)
        else $error("shared line driven while reading");
    a_slave_launch: assert property (@(posedge core_clk) disable iff (!rstSyncN)
        (!q.ctrl[CTRL_MASTER] && pinOut.sdoOe && $changed(pinOut.sdoOut)) |-> $past(fall))
        else $error("slave data moved off a falling clock");
    a_end_idle: assert property (@(posedge core_clk) disable iff (!rstSyncN)
        $fell(q.mst == M_RUN) |-> pinOut.sckOut == q.mode[MODE_CPOL])
        else $error("clock not idle after the eighth pulse");
endmodule

// [core/sms_pkg.sv]
package sms_pkg;

    // ------------------------------------------------------------
    // Register offsets, bit positions and reset values.
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_DATA = 8'h08;
    localparam logic [7:0] ADDR_CTRL = 8'h09;
    localparam logic [7:0] ADDR_CLKPIN = 8'h0A;
    localparam logic [7:0] ADDR_MODE = 8'h0B;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h11;
    localparam logic [7:0] CLKPIN_RST = 8'h05;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam int CTRL_CS = 0;
    localparam int CTRL_MASTER = 1;
    localparam int CTRL_ODIS = 2;
    localparam int CTRL_RDEN = 3;
    localparam int CTRL_AINC = 4;
    localparam int CTRL_SHARE = 5;
    localparam int CTRL_BUSY = 6;
    localparam int CLK_FN = 7;
    localparam int MODE_CPOL = 0;
    localparam int MODE_CPHA = 1;

    // ------------------------------------------------------------
    // Transfer and slave-link constants.
    // ------------------------------------------------------------
    localparam logic [3:0] EDGE_LAST = 4'hF;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
    localparam logic [7:0] SLV_KEY = 8'hA5;
    localparam logic [15:0] SLV_KEY_ADDR = 16'h000A;
    localparam logic [1:0] BUF_DEPTH = 2'h2;

    // ------------------------------------------------------------
    // Types.
    // ------------------------------------------------------------
    typedef enum logic {M_IDLE = 1'b0, M_RUN = 1'b1} sms_mst_t;
    typedef enum logic [2:0] {
        PH_CMD = 3'b000,
        PH_ADRH = 3'b001,
        PH_ADRL = 3'b010,
        PH_DUMMY = 3'b011,
        PH_DATA = 3'b100
    } sms_sph_t;
    typedef struct packed {logic wr; logic [15:0] addr; logic [7:0] data;} sms_req_t;
    typedef struct packed {logic wr; logic rd; logic [7:0] addr; logic [7:0] wdata;} sms_regreq_t;
    typedef struct packed {logic sck; logic selN; logic sdi; logic sdio;} sms_pin_in_t;
    typedef struct packed {
        logic sckOut; logic sckOe; logic selNOut; logic selNOe; logic sdoOut; logic sdoOe;
    } sms_pin_out_t;
    typedef struct packed {
        logic [7:0] ctrl, clkPin, mode, shift;
        sms_mst_t mst;
        logic [6:0] divCnt;
        logic [3:0] edgeCnt;
        logic rxb;
        logic [2:0] sckS, selNS, sdiS, sdioS;
        logic sckF, selNF, sdiF, sdioF, sckPrev;
        sms_sph_t sPh;
        logic [2:0] sBit;
        logic sCmdRd;
        logic [15:0] sAddr;
        logic [7:0] sRx, sTx;
        logic sLoad, sActive;
        logic [7:0] rdBuf;
        logic pend;
        sms_req_t pendReq;
        sms_req_t [1:0] bufMem;
        logic [1:0] bufCnt;
        logic bufValid;
        logic [7:0] rdData;
        sms_pin_out_t pinOut;
    } sms_state_t;

    localparam sms_pin_out_t PIN_RST = '{selNOut: 1'b1, default: 1'b0};
    localparam sms_state_t ST_RST = '{ctrl: CTRL_RST, clkPin: CLKPIN_RST, mode: MODE_RST,
        shift: DATA_RST, mst: M_IDLE, sPh: PH_CMD, selNS: 3'h7, selNF: 1'b1,
        pinOut: PIN_RST, default: '0};

endpackage

// [tb/sms_spi_peer.sv]
`timescale 1ns/1ps
module sms_spi_peer (
    // Link.
    input wire logic sck,
    input wire logic selN,
    input wire logic sdo,
    output logic sdi,
    // Setup and result.
    input wire logic cpha,
    input wire logic [7:0] txByte,
    output logic [7:0] rxByte
);
    logic [7:0] sh = 8'h00;
    int n = 0;
    initial begin
        sdi = 1'b0;
        rxByte = 8'h00;
    end
    always @(negedge selN) begin
        n = 0;
        sh = txByte;
        sdi = sh[7];
        if (!cpha) sh = {sh[6:0], 1'b0};
    end
    // A deselected peer leaves its line showing the inverse level.
    always @(posedge selN) sdi = ~sdi;
    always @(sck) begin
        if (!selN && n < 16) begin
            n = n + 1;
            if (n[0] ^ cpha) begin
                rxByte = {rxByte[6:0], sdo};
            end else begin
                sdi = sh[7];
                sh = {sh[6:0], 1'b0};
            end
        end
    end
endmodule

// [tb/tb_sms_port.sv]
`timescale 1ns/1ps
module tb_sms_port;
    import sms_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    sms_regreq_t regReq = '0;
    logic [7:0] regRdData;
    sms_pin_in_t pinIn;
    sms_pin_out_t pinOut;
    sms_req_t dmaReq;
    logic dmaValid;
    logic dmaReady = 1'b0;
    logic dmaRdValid = 1'b0;
    logic [7:0] dmaRdData = 8'h00, hostRx = 8'h00;
    logic hostOn = 1'b1, shareOn = 1'b0, hSck = 1'b0, hSelN = 1'b1, hSdi = 1'b0;
    logic ptSdi, ptCpha = 1'b0, sckPrev = 1'b0;
    logic [7:0] ptTx = 8'h00, ptRx, rd;
    int num_errors = 0, num_checks = 0, cyc = 0, tog = 0, firstT = 0, lastT = 0, oeSeen = 0;
    logic [7:0] regAddr [5] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C};
    logic [7:0] regExp [5] = '{8'h00, 8'h11, 8'h05, 8'h00, 8'h00};

    always #12.5 core_clk = ~core_clk;
    assign pinIn = '{sck: hSck, selN: hSelN, sdi: hostOn ? hSdi : (shareOn ? ~ptSdi : ptSdi),
        sdio: pinOut.sdoOe ? pinOut.sdoOut : (shareOn ? ptSdi : ~ptSdi)};

    sms_port u_sms_port (.core_clk(core_clk), .rst_n(rst_n), .regReq(regReq),
        .regRdData(regRdData), .pinIn(pinIn), .pinOut(pinOut), .dmaReq(dmaReq),
        .dmaValid(dmaValid), .dmaReady(dmaReady), .dmaRdValid(dmaRdValid),
        .dmaRdData(dmaRdData));
    sms_spi_peer u_sms_spi_peer (.sck(pinOut.sckOut), .selN(pinOut.selNOut),
        .sdo(pinOut.sdoOut), .sdi(ptSdi), .cpha(ptCpha), .txByte(ptTx), .rxByte(ptRx));

    // ------------------------------------------------------------
    // Clock edge monitor and run limit.
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        sckPrev <= pinOut.sckOut;
        if (pinOut.sdoOe) oeSeen <= oeSeen + 1;
        if (pinOut.sckOut !== sckPrev) begin
            tog <= tog + 1;
            lastT <= cyc;
            if (tog == 0) firstT <= cyc;
        end
        if (cyc == 40000) begin
            num_errors++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // Tasks.
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic regWr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        regReq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge core_clk);
        regReq = '0;
    endtask
    task automatic regRd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        regReq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge core_clk);
        regReq = '0;
        @(negedge core_clk);
        d = regRdData;
    endtask
    task automatic hostFrame(input logic [7:0] b[$]);
        hSelN = 1'b0;
        foreach (b[i]) for (int j = 7; j >= 0; j--) begin
            hSdi = b[i][j];
            repeat (4) @(negedge core_clk);
            hSck = 1'b1;
            repeat (4) @(negedge core_clk);
            hostRx = {hostRx[6:0], pinOut.sdoOut};
            hSck = 1'b0;
        end
        repeat (4) @(negedge core_clk);
        hSelN = 1'b1;
        hSdi = ~hSdi;
        repeat (8) @(negedge core_clk);
    endtask
    task automatic xfer(input logic [7:0] ctl, input logic [1:0] m, input logic [6:0] dv,
        input logic [7:0] tx, input logic wrOp);
        int k;
        regWr(ADDR_CTRL, ctl | 8'h01);
        regWr(ADDR_MODE, {6'h00, m});
        regWr(ADDR_CLKPIN, {1'b1, dv});
        check(pinOut.sckOut, m[MODE_CPOL]);
        check({pinOut.sckOe, pinOut.selNOe, pinOut.selNOut}, 3'b111);
        ptCpha = m[MODE_CPHA];
        regWr(ADDR_CTRL, ctl);
        tog = 0;
        oeSeen = 0;
        if (wrOp) regWr(ADDR_DATA, tx);
        else regRd(ADDR_DATA, rd);
        check(pinOut.selNOut, 1'b0);
        regRd(ADDR_CTRL, rd);
        check(rd[CTRL_BUSY], 1'b1);
        for (k = 0; k < 1000 && rd[CTRL_BUSY] !== 1'b0; k++) regRd(ADDR_CTRL, rd);
        check(rd[CTRL_BUSY], 1'b0);
        check(tog, 16);
        check(lastT - firstT, 15 * (dv + 1));
        check(pinOut.sckOut, m[MODE_CPOL]);
        regWr(ADDR_CTRL, ctl | 8'h01);
    endtask

    // ------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        foreach (regAddr[i]) begin
            regRd(regAddr[i], rd);
            check(rd, regExp[i]);
        end
        hostFrame({8'h00, 8'h12, 8'h34, 8'h00, 8'h77});
        hostFrame({8'h00, 8'h00, 8'h0A, 8'h00, SLV_KEY});
        check(dmaValid, 1'b0);
        regRd(ADDR_CLKPIN, rd);
        check(rd, SLV_KEY);
        hostFrame({8'h00, 8'h12, 8'h34, 8'h00, 8'h5A, 8'h5B});
        check({dmaValid, dmaReq}, {1'b1, 1'b1, 16'h1234, 8'h5A});
        dmaReady = 1'b1;
        @(negedge core_clk);
        dmaReady = 1'b0;
        check({dmaValid, dmaReq}, {1'b1, 1'b1, 16'h1235, 8'h5B});
        dmaReady = 1'b1;
        @(negedge core_clk);
        dmaReady = 1'b0;
        check(dmaValid, 1'b0);
        fork
            hostFrame({8'h80, 8'h12, 8'h40, 8'h00, 8'h00});
            begin
                wait (dmaValid);
                @(negedge core_clk);
                check({dmaValid, dmaReq}, {1'b1, 1'b0, 16'h1240, 8'h00});
                dmaReady = 1'b1;
                dmaRdValid = 1'b1;
                dmaRdData = 8'hC7;
                @(negedge core_clk);
                dmaReady = 1'b0;
                dmaRdValid = 1'b0;
            end
        join
        check(hostRx, 8'hC7);
        check({dmaValid, dmaReq}, {1'b1, 1'b0, 16'h1241, 8'h00});
        dmaReady = 1'b1;
        repeat (2) @(negedge core_clk);
        dmaReady = 1'b0;
        check(dmaValid, 1'b0);
        hostOn = 1'b0;
        regWr(ADDR_CLKPIN, 8'h05);
        regWr(ADDR_CTRL, 8'h03);
        check(pinOut.sckOe, 1'b0);
        for (int m = 0; m < 4; m++) begin
            xfer(8'h02, m[1:0], (m == 3) ? 7'h7F : 7'(m), 8'h96 ^ 8'(m), 1'b1);
            check(ptRx, 8'h96 ^ 8'(m));
            check(oeSeen > 0, 1'b1);
        end
        xfer(8'h06, 2'h0, 7'h01, 8'hFF, 1'b1);
        check(oeSeen, 0);
        for (int s = 0; s < 2; s++) begin
            shareOn = s[0];
            ptTx = s[0] ? 8'h3C : 8'hC3;
            xfer(s[0] ? 8'h2E : 8'h0E, 2'h3, 7'h04, 8'h00, 1'b0);
            regWr(ADDR_CTRL, 8'h03);
            regRd(ADDR_DATA, rd);
            check(rd, ptTx);
        end
        regWr(ADDR_CTRL, 8'h06);
        tog = 0;
        regRd(ADDR_DATA, rd);
        repeat (40) @(negedge core_clk);
        check(tog, 0);
        print_verdict();
    end
endmodule
